// ===== fault_alert_interface.sv
// Fault alert aggregation, output driver and incoming alert receiver
`timescale 1ns/100ps
`default_nettype none
`include "alert_fault_defines.svh"
module fault_alert_interface #(
   parameter int unsigned QUAL_CYCLES = `QUAL_CYC
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   // Status and mask
   input  wire logic [15:0]                   primary_status_register,
   input  wire logic [15:0]                   alert_mask_register,
   input  wire logic                          user_alert_force,
   // Configuration
   input  wire logic                          alert_output_enable,
   input  wire logic                          host_port_select,
   input  wire alert_fault_pkg::link_config_type link_config_field,
   input  wire logic                          spi_alert_drive_select,
   input  wire logic                          idle_float_select,
   input  wire logic                          dc_test_enable,
   input  wire logic                          scan_update,
   // Balance switch diagnostics
   input  wire logic [13:0]                   balance_switch_fault,
   input  wire logic [3:0]                    top_cell_one,
   input  wire logic [3:0]                    top_cell_two,
   // Alert pins
   input  wire logic                          alert_input_pin,
   output logic                               alert_output_pin,
   output logic                               alert_output_oe,
   output logic                               diff_alert_wave,
   // Status outputs
   output logic [15:0]                        status_readback,
   output logic [15:0]                        alert_packet_status_word,
   output logic [13:0]                        balance_switch_alert,
   output logic                               alert_active,
   output logic                               incoming_alert
);
   import alert_fault_pkg::*;

   localparam logic [6:0] WAVE_LAST = 7'(`WAVE_PERIOD_CYC - 1);
   localparam logic [6:0] WAVE_HIGH = 7'(`WAVE_HIGH_CYC);

   function automatic logic [13:0] cells_in_use(input logic [3:0] top);
      logic [13:0] m;
      m = 14'h0000;
      for (int i = 0; i < `CELL_COUNT; i++) begin
         m[i] = (4'(i) < top);
      end
      return m;
   endfunction

   // Mode decode
   wire uart_mode = host_port_select;
   wire spi_mode = ~host_port_select;
   wire diff_cfg = (link_config_field == LINK_DIFF);

   // Balance switch masking
   wire        tops_equal = (top_cell_one == top_cell_two);
   wire [13:0] bal_keep = tops_equal ? cells_in_use(top_cell_one) : 14'h3fff;
   wire [13:0] next_bal = balance_switch_fault & bal_keep;

   // Alert aggregation
   wire [15:0] masked = primary_status_register & alert_mask_register;
   wire        por = primary_status_register[`BIT_POR];
   wire        local_fault = (|(masked & 16'(`ALERT_MASKED_FIELDS))) | por;
   wire [15:0] next_packet = (masked & 16'(`PKT_MASKED_FIELDS)) | {1'b0, por, 14'h0000};

   // Incoming alert receiver
   wire rx_data = alert_input_pin & ~1'b0;
   wire rx_enable = alert_output_enable & uart_mode;
   wire rx_valid;

   alert_wave_qualifier #(
      .QUAL_CYCLES(QUAL_CYCLES)
   ) u_rx (
      .clk      (clk),
      .reset_n  (reset_n),
      .enable   (rx_enable),
      .wave_in  (rx_data),
      .qualified(rx_valid)
   );

   wire next_active = alert_output_enable & (local_fault | user_alert_force | incoming_alert);

   // Scan-rate latch of the UART alert state
   logic uart_alert;
   wire  next_uart_alert = scan_update ? alert_active : uart_alert;

   // Square wave generator
   logic [6:0] wave_cnt;
   wire        wave = (wave_cnt < WAVE_HIGH);
   wire [6:0]  next_wave_cnt = (!uart_alert || wave_cnt == WAVE_LAST) ? 7'h00 : wave_cnt + 7'h01;

   // Output driver selection
   logic next_out;
   logic next_oe;
   always_comb begin
      next_out = 1'b0;
      next_oe = 1'b0;
      if (spi_mode) begin
         next_out = ~alert_active & spi_alert_drive_select;
         next_oe = alert_active | spi_alert_drive_select;
      end else if (dc_test_enable) begin
         next_out = ~alert_active;
         next_oe = 1'b1;
      end else if (uart_alert && !diff_cfg) begin
         next_out = wave;
         next_oe = 1'b1;
      end else begin
         next_out = 1'b0;
         next_oe = ~idle_float_select;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         alert_active <= 1'b0;
         uart_alert <= 1'b0;
         wave_cnt <= 7'h00;
         alert_output_pin <= 1'b0;
         alert_output_oe <= 1'b0;
         diff_alert_wave <= 1'b0;
         incoming_alert <= 1'b0;
         status_readback <= `STATUS_RESET;
         alert_packet_status_word <= `STATUS_RESET;
         balance_switch_alert <= 14'h0000;
      end else begin
         alert_active <= next_active;
         uart_alert <= next_uart_alert & uart_mode & alert_output_enable;
         wave_cnt <= next_wave_cnt;
         alert_output_pin <= next_out;
         alert_output_oe <= next_oe;
         diff_alert_wave <= uart_alert & diff_cfg & wave;
         incoming_alert <= rx_valid & rx_enable;
         status_readback <= primary_status_register;
         alert_packet_status_word <= next_packet;
         balance_switch_alert <= next_bal;
      end
   end

   property p_mask_or;
      @(posedge clk) disable iff (!reset_n)
      (alert_output_enable && (|(primary_status_register & alert_mask_register & `ALERT_MASKED_FIELDS)))
         |=> alert_active;
   endproperty
   a_mask_or: assert property (p_mask_or) else $error("enabled fault gave no alert");

   property p_por;
      @(posedge clk) disable iff (!reset_n)
      (alert_output_enable && primary_status_register[14] && alert_mask_register == 16'h0000)
         |=> alert_active && alert_packet_status_word[14];
   endproperty
   a_por: assert property (p_por) else $error("reset flag was masked");

   property p_readback;
      @(posedge clk) disable iff (!reset_n)
      ##1 status_readback == $past(primary_status_register);
   endproperty
   a_readback: assert property (p_readback) else $error("status readback altered");

   property p_packet_zero;
      @(posedge clk) disable iff (!reset_n)
      alert_packet_status_word[15] == 1'b0 && alert_packet_status_word[6] == 1'b0;
   endproperty
   a_packet_zero: assert property (p_packet_zero) else $error("packet reserved bit set");

   property p_packet_mask;
      @(posedge clk) disable iff (!reset_n)
      (alert_mask_register == 16'h0000) |=> alert_packet_status_word[13:0] == 14'h0000;
   endproperty
   a_packet_mask: assert property (p_packet_mask) else $error("masked flag in packet");

   property p_scan_only;
      @(posedge clk) disable iff (!reset_n)
      (primary_status_register == 16'h8000) |=> alert_packet_status_word == 16'h0000;
   endproperty
   a_scan_only: assert property (p_scan_only) else $error("scan flag in packet");

   property p_force_spi;
      @(posedge clk) disable iff (!reset_n)
      (alert_output_enable && user_alert_force && spi_mode)[*2]
         |=> !alert_output_pin && alert_output_oe;
   endproperty
   a_force_spi: assert property (p_force_spi) else $error("forced alert not driven");

   property p_disabled;
      @(posedge clk) disable iff (!reset_n)
      !alert_output_enable |=> !alert_active && !incoming_alert;
   endproperty
   a_disabled: assert property (p_disabled) else $error("alert while disabled");

   property p_spi_od;
      @(posedge clk) disable iff (!reset_n)
      (spi_mode && !spi_alert_drive_select && !alert_active) |=> !alert_output_oe;
   endproperty
   a_spi_od: assert property (p_spi_od) else $error("open drain drove idle");

   property p_spi_rx;
      @(posedge clk) disable iff (!reset_n)
      spi_mode |=> !incoming_alert;
   endproperty
   a_spi_rx: assert property (p_spi_rx) else $error("input used in SPI mode");

   property p_wave_half;
      @(posedge clk) disable iff (!reset_n)
      (uart_alert && wave_cnt == 7'h00) |-> ##62 (!uart_alert || wave_cnt == WAVE_HIGH);
   endproperty
   a_wave_half: assert property (p_wave_half) else $error("wave half period wrong");

   property p_scan_hold;
      @(posedge clk) disable iff (!reset_n)
      (!scan_update && uart_mode && alert_output_enable) |=> uart_alert == $past(uart_alert);
   endproperty
   a_scan_hold: assert property (p_scan_hold) else $error("alert refreshed off scan");

   property p_idle_float;
      @(posedge clk) disable iff (!reset_n)
      (uart_mode && !dc_test_enable && !uart_alert && idle_float_select) |=> !alert_output_oe;
   endproperty
   a_idle_float: assert property (p_idle_float) else $error("idle output not floating");

   property p_dc_test;
      @(posedge clk) disable iff (!reset_n)
      (uart_mode && dc_test_enable) |=> alert_output_oe && alert_output_pin == !$past(alert_active);
   endproperty
   a_dc_test: assert property (p_dc_test) else $error("dc test level wrong");

   property p_diff_single;
      @(posedge clk) disable iff (!reset_n)
      (uart_mode && diff_cfg && !dc_test_enable) |=> !alert_output_pin;
   endproperty
   a_diff_single: assert property (p_diff_single) else $error("single-ended alert in differential");

   property p_top_unequal;
      @(posedge clk) disable iff (!reset_n)
      (top_cell_one != top_cell_two) |=> balance_switch_alert == $past(balance_switch_fault);
   endproperty
   a_top_unequal: assert property (p_top_unequal) else $error("balance fault masked");
endmodule
`default_nettype wire

// ===== alert_fault_defines.svh
// Offsets, field positions and timing counts for the fault alert block
// Summary of operation
// - Alert asserts when any status flag except bit 6 and its mask enable are both set.
// - Power-on reset flag raises alert and packet with no mask.
// - Masking only affects alerting and packet; status stays readable unchanged.
// - Packet bits 15,6 zero; 14 raw reset flag; 13..7 masked faults.
// - Packet bits 5..0 are masked packet, interface, cal, balance, diag flags.
// - Scan-done flag never in packet; alerts only when enabled.
// - User force bit drives the alert active without any fault.
// - Link config selects loopback, differential or dual link arrangement.
// - Interface disabled means no alert on any path, input ignored.
// - Port select 0 is SPI, 1 is UART with AC CMOS driver.
// - SPI alert active low; open drain floats idle, CMOS drives high.
// - In SPI mode the alert input pin is ignored.
// - UART non-differential fault gives continuous 2MHz square wave, high 62 of 125 cycles.
// - UART alert state refreshes at scan rate, not continuously.
// - UART idle output low with float select 0, high-Z with 1.
// - Incoming wave accepted only after 25us at correct frequency.
// - Input is single-ended receiver with grounded negative input.
// - Top-cell settings mask balance switch faults; unequal masks none.
// - DC test in UART drives low on alert, high otherwise.
`ifndef ALERT_FAULT_DEFINES_SVH
`define ALERT_FAULT_DEFINES_SVH
`define BIT_SCAN_DONE     15
`define BIT_POR           14
`define BIT_PKT_ZERO_HI   15
`define BIT_PKT_ZERO_LO   6
`define PKT_MASKED_FIELDS 16'h3fbf
`define ALERT_MASKED_FIELDS 16'hbfbf
`define STATUS_RESET      16'h0000
`define CLK_PERIOD_NS     4
`define WAVE_PERIOD_NS    500
`define WAVE_PERIOD_CYC   (`WAVE_PERIOD_NS / `CLK_PERIOD_NS)
`define WAVE_HIGH_CYC     (`WAVE_PERIOD_CYC / 2)
`define WAVE_TOL_CYC      12
`define QUAL_TIME_NS      25000
`define QUAL_CYC          ((`QUAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CELL_COUNT        14
`endif

// ===== alert_fault_pkg.sv
// Types shared by the fault alert block
`default_nettype none
package alert_fault_pkg;
   typedef enum logic [1:0] {
      LINK_EXT_LOOP = 2'h0,
      LINK_INT_LOOP = 2'h1,
      LINK_DIFF     = 2'h2,
      LINK_DUAL     = 2'h3
   } link_config_type;
   typedef enum logic [2:0] {
      RX_IDLE    = 3'h1,
      RX_QUALIFY = 3'h2,
      RX_VALID   = 3'h4
   } rx_state_type;
endpackage
`default_nettype wire

// ===== alert_wave_qualifier.sv
// Qualifies an incoming alert square wave by period and duration
`timescale 1ns/100ps
`default_nettype none
`include "alert_fault_defines.svh"
module alert_wave_qualifier #(
   parameter int unsigned QUAL_CYCLES = `QUAL_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Wave input
   input  wire logic enable,
   input  wire logic wave_in,
   // Result
   output logic      qualified
);
   import alert_fault_pkg::*;
   localparam logic [7:0] PER_MIN = 8'(`WAVE_PERIOD_CYC - `WAVE_TOL_CYC);
   localparam logic [7:0] PER_MAX = 8'(`WAVE_PERIOD_CYC + `WAVE_TOL_CYC);
   localparam logic [15:0] QUAL_LIM = 16'(QUAL_CYCLES);

   rx_state_type state;
   rx_state_type next_state;
   logic         wave_prev;
   logic [7:0]   period;
   logic [15:0]  run;
   wire          rise = wave_in & ~wave_prev;
   wire          per_ok = (period >= PER_MIN) && (period <= PER_MAX);
   wire          stale = (period > PER_MAX);
   wire          bad = (rise & ~per_ok) | stale | ~enable;

   always_comb begin
      next_state = state;
      unique case (state)
         RX_IDLE: begin
            if (enable && rise) next_state = RX_QUALIFY;
         end
         RX_QUALIFY: begin
            if (bad) next_state = RX_IDLE;
            else if (run >= QUAL_LIM) next_state = RX_VALID;
         end
         RX_VALID: begin
            if (bad) next_state = RX_IDLE;
         end
         default: next_state = RX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= RX_IDLE;
         wave_prev <= 1'b0;
         period <= 8'h00;
         run <= 16'h0000;
      end else begin
         state <= next_state;
         wave_prev <= wave_in;
         period <= (rise || stale) ? 8'h01 : period + 8'h01;
         run <= (next_state == RX_IDLE) ? 16'h0000 : run + 16'h0001;
      end
   end

   assign qualified = (state == RX_VALID);

   property p_qual_time;
      @(posedge clk) disable iff (!reset_n)
      $rose(qualified) |-> run > QUAL_LIM;
   endproperty
   a_qual_time: assert property (p_qual_time) else $error("alert accepted too early");

   property p_bad_period;
      @(posedge clk) disable iff (!reset_n)
      (state != RX_IDLE && rise && !per_ok) |=> !qualified && run == 16'h0000;
   endproperty
   a_bad_period: assert property (p_bad_period) else $error("bad period not rejected");
endmodule
`default_nettype wire

// ===== alert_upstream_model.sv
// Upstream neighbour sending an alert square wave into the block
`timescale 1ns/100ps
`default_nettype none
module alert_upstream_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Control
   input  wire logic       send,
   input  wire logic [7:0] period,
   // Wave
   output logic            wave
);
   logic [7:0] phase;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase <= 8'h00;
         wave  <= 1'b0;
      end else if (!send) begin
         phase <= 8'h00;
         wave  <= 1'b0;
      end else begin
         phase <= (phase + 8'h01 >= period) ? 8'h00 : phase + 8'h01;
         wave  <= (phase < (period >> 1));
      end
   end
endmodule
`default_nettype wire

// ===== fault_alert_interface_tb_top.sv
// Self-checking bench for the fault alert block
`timescale 1ns/100ps
`default_nettype none
module fault_alert_interface_tb_top;
   import alert_fault_pkg::*;
   localparam int unsigned QUAL = 300;
   logic            clk = 1'b0;
   logic            reset_n = 1'b0;
   logic [15:0]     status = 16'h0000;
   logic [15:0]     mask = 16'h0000;
   logic            force_on = 1'b0;
   logic            en = 1'b0;
   logic            hsel = 1'b0;
   link_config_type cfg = LINK_EXT_LOOP;
   logic            drv = 1'b0;
   logic            flt = 1'b0;
   logic            dct = 1'b0;
   logic            scan = 1'b0;
   logic [13:0]     bsf = 14'h0000;
   logic [3:0]      top1 = 4'h0;
   logic [3:0]      top2 = 4'h0;
   logic            send = 1'b0;
   logic [7:0]      period = 8'h7d;
   logic            ain, pin, oe, diffw, active, incoming;
   logic [15:0]     readback, word;
   logic [13:0]     bal;
   wire             line = oe ? pin : 1'b1;
   int              failures = 0;
   int              check_count = 0;
   logic [15:0]     cs [3] = '{16'h4000, 16'h8000, 16'hffff};
   logic [15:0]     cm [3] = '{16'h0000, 16'h8000, 16'hbfbf};

   always #2 clk = ~clk;

   fault_alert_interface #(.QUAL_CYCLES(QUAL)) fault_alert_interface_inst (
      .clk(clk), .reset_n(reset_n), .primary_status_register(status), .alert_mask_register(mask),
      .user_alert_force(force_on), .alert_output_enable(en), .host_port_select(hsel),
      .link_config_field(cfg), .spi_alert_drive_select(drv), .idle_float_select(flt),
      .dc_test_enable(dct), .scan_update(scan), .balance_switch_fault(bsf), .top_cell_one(top1),
      .top_cell_two(top2), .alert_input_pin(ain), .alert_output_pin(pin), .alert_output_oe(oe),
      .diff_alert_wave(diffw), .status_readback(readback), .alert_packet_status_word(word),
      .balance_switch_alert(bal), .alert_active(active), .incoming_alert(incoming));

   alert_upstream_model alert_upstream_model_inst (
      .clk(clk), .reset_n(reset_n), .send(send), .period(period), .wave(ain));

   task automatic final_report;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulse_scan;
      @(posedge clk);
      scan <= 1'b1;
      @(posedge clk);
      scan <= 1'b0;
      settle(3);
   endtask

   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (line === lvl && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 400) begin
         failures++;
         final_report();
      end
   endtask

   task automatic watch(input int n, output logic hit);
      hit = 1'b0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (incoming === 1'b1) hit = 1'b1;
      end
   endtask

   task automatic count_high(input int n, output int k);
      k = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (diffw === 1'b1) k++;
      end
   endtask

   function automatic logic [15:0] exp_packet(input logic [15:0] s, input logic [15:0] m);
      exp_packet = (s & m & 16'h3fbf) | (s & 16'h4000);
   endfunction

   function automatic logic exp_active(input logic [15:0] s, input logic [15:0] m, input logic f);
      exp_active = (|(s & m & 16'hbfbf)) | s[14] | f;
   endfunction

   function automatic logic [13:0] exp_bal(input logic [13:0] f, input logic [3:0] a, input logic [3:0] b);
      exp_bal = f;
      if (a == b)
         for (int i = 0; i < 14; i++)
            if (i + 1 > a) exp_bal[i] = 1'b0;
   endfunction

   initial begin
      #400000;
      failures++;
      final_report();
   end

   initial begin
      logic       a;
      logic       hit;
      int         h;
      int         l;
      logic [3:0] t;
      h = $urandom(47);
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      en <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         t = 4'($urandom_range(14, 0));
         status <= (i < 3) ? cs[i] : 16'($urandom & $urandom & $urandom);
         mask <= (i < 3) ? cm[i] : 16'($urandom);
         force_on <= (i % 8 == 3);
         drv <= 1'($urandom);
         bsf <= 14'($urandom);
         top1 <= t;
         top2 <= (i % 3 == 0) ? 4'($urandom) : t;
         settle(3);
         a = exp_active(status, mask, force_on);
         check("packet", word, exp_packet(status, mask));
         check("readback", readback, status);
         check("active", 16'(active), 16'(a));
         check("spi_line", 16'({oe, line}), 16'({drv | a, ~a}));
         check("balance", 16'(bal), 16'(exp_bal(bsf, top1, top2)));
      end
      @(posedge clk);
      {en, drv, force_on, status} <= {1'b0, 1'b1, 1'b0, 16'h4000};
      settle(3);
      check("disabled", 16'({oe, line}), 16'h0003);
      @(posedge clk);
      {en, hsel, status, mask} <= {1'b1, 1'b1, 16'h0000, 16'h0008};
      pulse_scan;
      check("idle_low", 16'({oe, pin}), 16'h0002);
      @(posedge clk);
      flt <= 1'b1;
      pulse_scan;
      check("idle_float", 16'(oe), 16'h0000);
      @(posedge clk);
      flt <= 1'b0;
      pulse_scan;
      @(posedge clk);
      status <= 16'h0008;
      settle(8);
      check("held", 16'(line), 16'h0000);
      for (int c = 0; c < 4; c++) begin
         if (c == 2) continue;
         @(posedge clk);
         cfg <= link_config_type'(c);
         pulse_scan;
         run_len(1'b1, h);
         run_len(1'b0, h);
         run_len(1'b1, h);
         run_len(1'b0, l);
         check("wave_high", 16'(h), 16'h003e);
         check("wave_low", 16'(l), 16'h003f);
         check("diff_idle", 16'(diffw), 16'h0000);
      end
      @(posedge clk);
      cfg <= LINK_DIFF;
      pulse_scan;
      check("diff_line", 16'({oe, pin}), 16'h0002);
      count_high(125, l);
      check("diff_wave", 16'(l), 16'h003e);
      @(posedge clk);
      dct <= 1'b1;
      settle(3);
      check("dc_on", 16'({oe, line}), 16'h0002);
      @(posedge clk);
      status <= 16'h0000;
      settle(3);
      check("dc_off", 16'({oe, line}), 16'h0003);
      @(posedge clk);
      {dct, cfg} <= {1'b0, LINK_EXT_LOOP};
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         {hsel, en, send} <= {k != 3, k != 4, 1'b1};
         period <= (k == 2) ? 8'ha0 : (k == 5) ? 8'h64 : 8'h7d;
         watch((k == 1) ? QUAL / 2 : QUAL + 60, hit);
         if (k == 0) check("repeat", 16'(active), 16'h0001);
         @(posedge clk);
         send <= 1'b0;
         check("incoming", 16'(hit), 16'(k == 0));
         watch(200, hit);
         if (k > 0) check("late", 16'(hit), 16'h0000);
      end
      final_report();
   end
endmodule
`default_nettype wire
